// *** hdl/cbc_pkg.sv ***
// Constants, types and the bit unit for the bit, logic and call executor
//
// Notes on behaviour
// - The AND-immediate instruction ANDs the accumulator with an 8-bit immediate into the accumulator, updates only zero, and takes one cycle.
// - The bit-set instruction forces bit 0..7 of file register 0..127 to one, leaves all flags alone, and takes one cycle.
// - The skip-if-clear instruction suppresses the next instruction when the selected file bit is zero and alters no flag.
// - The skip-if-set instruction suppresses the next instruction when the selected file bit is one and alters no flag.
// - A taken skip discards the fetched next instruction and runs a no-operation instead (two cycles), else the test takes one cycle.
// - The computed call pushes the program counter plus one onto the top of the return stack and advances the stack pointer.
// - The computed call loads program counter 10:8 from call-high bits 2:0 and 7:0 from the accumulator, takes two cycles, changes no flag.
// - The clear-accumulator instruction writes zero to the accumulator, sets zero to one, and takes one cycle.

package cbc_pkg;

    //------------------------------------------------------------------
    // Widths and positions
    //------------------------------------------------------------------
    localparam int DATA_W      = 8;
    localparam int FADDR_W     = 7;
    localparam int BIT_W       = 3;
    localparam int PC_W        = 11;
    localparam int SP_W        = 3;
    localparam int STACK_DEPTH = 8;
    localparam int PC_HI_MSB   = 10;
    localparam int PC_HI_LSB   = 8;
    localparam int CALL_HI_MSB = 2;
    localparam int CALL_HI_LSB = 0;

    //------------------------------------------------------------------
    // Reset values and the clear-accumulator value
    //------------------------------------------------------------------
    localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
    localparam logic              ZERO_RESET = 1'b0;
    localparam logic [PC_W-1:0]   PC_RESET   = 11'h000;
    localparam logic [SP_W-1:0]   SP_RESET   = 3'h0;
    localparam logic [DATA_W-1:0] ACC_CLEAR  = 8'h00;

    //------------------------------------------------------------------
    // Types
    //------------------------------------------------------------------
    typedef enum logic [2:0] {
        CBC_OP_NONE,
        CBC_OP_AND_IMMEDIATE,
        CBC_OP_BIT_SET,
        CBC_OP_SKIP_IF_BIT_CLEAR,
        CBC_OP_SKIP_IF_BIT_SET,
        CBC_OP_COMPUTED_CALL,
        CBC_OP_CLEAR_ACCUMULATOR
    } cbc_op_t;

    typedef struct packed {
        cbc_op_t              op;
        logic [DATA_W-1:0]    imm;
        logic [FADDR_W-1:0]   faddr;
        logic [BIT_W-1:0]     bit_sel;
    } cbc_instr_t;

    typedef struct packed {
        logic                 we;
        logic [FADDR_W-1:0]   addr;
        logic [DATA_W-1:0]    data;
    } cbc_fwrite_t;

    function automatic logic [DATA_W-1:0] cbc_bit_mask(
        input logic [BIT_W-1:0] sel
    );
        cbc_bit_mask = 8'h01 << sel;
    endfunction : cbc_bit_mask

endpackage : cbc_pkg

`timescale 1ns/100ps

module cbc_bit_unit (
    input  wire logic [cbc_pkg::DATA_W-1:0] data,
    input  wire logic [cbc_pkg::BIT_W-1:0]  sel,
    output logic                            bit_val,
    output logic [cbc_pkg::DATA_W-1:0]      set_data
);

    assign bit_val  = |(data & cbc_pkg::cbc_bit_mask(sel));
    assign set_data = data | cbc_pkg::cbc_bit_mask(sel);

endmodule : cbc_bit_unit

// *** hdl/cbc_exec.sv ***
// Executor for AND-immediate, bit set, bit-test skips, computed call, clear
`timescale 1ns/100ps

module cbc_exec (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        instr_valid,
    output logic                             instr_ready,
    input  wire cbc_pkg::cbc_instr_t         instr,
    input  wire logic [cbc_pkg::DATA_W-1:0]  call_high_addr_reg,
    input  wire logic                        acc_load,
    input  wire logic [cbc_pkg::DATA_W-1:0]  acc_load_data,
    output logic [cbc_pkg::FADDR_W-1:0]      file_raddr,
    input  wire logic [cbc_pkg::DATA_W-1:0]  file_rdata,
    output cbc_pkg::cbc_fwrite_t             file_wr_ff,
    output logic                             fetch_discard,
    output logic                             nop_cycle_ff,
    output logic [cbc_pkg::DATA_W-1:0]       accumulator_ff,
    output logic                             zero_flag_ff,
    output logic [cbc_pkg::PC_W-1:0]         pc_ff,
    output logic [cbc_pkg::SP_W-1:0]         stack_ptr_ff,
    output logic [cbc_pkg::PC_W-1:0]         stack_top
);

    //------------------------------------------------------------------
    // Decode
    //------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SKIP,
        ST_CALL
    } cbc_state_t;

    cbc_state_t                    state_ff;
    cbc_state_t                    nxt_state;
    logic [cbc_pkg::PC_W-1:0]      stack_ff [cbc_pkg::STACK_DEPTH];
    logic [cbc_pkg::PC_W-1:0]      call_target_ff;
    logic [cbc_pkg::PC_W-1:0]      pc_plus_one;
    logic [cbc_pkg::DATA_W-1:0]    and_result;
    logic [cbc_pkg::DATA_W-1:0]    set_data;
    logic                          sel_bit;
    logic                          accept;
    logic                          skip_take;

    cbc_bit_unit u_bit (
        .data     (file_rdata),
        .sel      (instr.bit_sel),
        .bit_val  (sel_bit),
        .set_data (set_data)
    );

    assign instr_ready = (state_ff == ST_IDLE);
    assign accept      = instr_valid && instr_ready;
    assign file_raddr  = instr.faddr;
    assign pc_plus_one = pc_ff + 11'h001;
    assign and_result  = accumulator_ff & instr.imm;
    assign stack_top   = stack_ff[stack_ptr_ff - 3'h1];

    assign skip_take = accept &&
        ((instr.op == cbc_pkg::CBC_OP_SKIP_IF_BIT_CLEAR && !sel_bit) ||
         (instr.op == cbc_pkg::CBC_OP_SKIP_IF_BIT_SET && sel_bit));
    assign fetch_discard = skip_take;

    //------------------------------------------------------------------
    // Sequencing
    //------------------------------------------------------------------
    always_comb
    begin
        nxt_state = ST_IDLE;
        case (state_ff)
            ST_IDLE:
            begin
                if (skip_take)
                    nxt_state = ST_SKIP;
                else if (accept &&
                         instr.op == cbc_pkg::CBC_OP_COMPUTED_CALL)
                    nxt_state = ST_CALL;
            end
            ST_SKIP: nxt_state = ST_IDLE;
            ST_CALL: nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            nop_cycle_ff <= 1'b0;
        else
            nop_cycle_ff <= skip_take;
    end

    //------------------------------------------------------------------
    // Accumulator and zero flag
    //------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            accumulator_ff <= cbc_pkg::ACC_RESET;
            zero_flag_ff   <= cbc_pkg::ZERO_RESET;
        end
        else if (accept)
        begin
            case (instr.op)
                cbc_pkg::CBC_OP_AND_IMMEDIATE:
                begin
                    accumulator_ff <= and_result;
                    zero_flag_ff   <= (and_result == 8'h00);
                end
                cbc_pkg::CBC_OP_CLEAR_ACCUMULATOR:
                begin
                    accumulator_ff <= cbc_pkg::ACC_CLEAR;
                    zero_flag_ff   <= 1'b1;
                end
                default:
                begin
                    if (acc_load)
                        accumulator_ff <= acc_load_data;
                    zero_flag_ff <= zero_flag_ff;
                end
            endcase
        end
        // Results of instructions outside this set
        else if (acc_load)
            accumulator_ff <= acc_load_data;
    end

    //------------------------------------------------------------------
    // File register write
    //------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            file_wr_ff <= '0;
        else
        begin
            file_wr_ff.we   <= accept &&
                               instr.op == cbc_pkg::CBC_OP_BIT_SET;
            file_wr_ff.addr <= instr.faddr;
            file_wr_ff.data <= set_data;
        end
    end

    //------------------------------------------------------------------
    // Program counter
    //------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            call_target_ff <= cbc_pkg::PC_RESET;
        else if (accept)
            call_target_ff <= {call_high_addr_reg[cbc_pkg::CALL_HI_MSB:
                                                  cbc_pkg::CALL_HI_LSB],
                               accumulator_ff};
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pc_ff <= cbc_pkg::PC_RESET;
        else if (state_ff == ST_CALL)
            pc_ff <= call_target_ff;
        else if (state_ff == ST_SKIP || accept)
            pc_ff <= pc_plus_one;
    end

    //------------------------------------------------------------------
    // Return stack
    //------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            stack_ptr_ff <= cbc_pkg::SP_RESET;
            for (int i = 0; i < cbc_pkg::STACK_DEPTH; i++)
                stack_ff[i] <= cbc_pkg::PC_RESET;
        end
        else if (accept && instr.op == cbc_pkg::CBC_OP_COMPUTED_CALL)
        begin
            stack_ff[stack_ptr_ff] <= pc_plus_one;
            stack_ptr_ff           <= stack_ptr_ff + 3'h1;
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    property p_and_imm;
        @(posedge clk) disable iff (reset)
        accept && instr.op == cbc_pkg::CBC_OP_AND_IMMEDIATE |=>
            accumulator_ff == ($past(accumulator_ff) & $past(instr.imm)) &&
            zero_flag_ff == (accumulator_ff == 8'h00) && instr_ready;
    endproperty
    a_and_imm: assert property (p_and_imm)
        else $error("AND immediate result or zero flag wrong");

    property p_bit_set;
        @(posedge clk) disable iff (reset)
        accept && instr.op == cbc_pkg::CBC_OP_BIT_SET |=>
            file_wr_ff.we && file_wr_ff.addr == $past(instr.faddr) &&
            file_wr_ff.data == ($past(file_rdata) |
                cbc_pkg::cbc_bit_mask($past(instr.bit_sel))) &&
            $stable(zero_flag_ff) && instr_ready;
    endproperty
    a_bit_set: assert property (p_bit_set)
        else $error("Bit set write wrong or flag changed");

    property p_skip_clear;
        @(posedge clk) disable iff (reset)
        accept && instr.op == cbc_pkg::CBC_OP_SKIP_IF_BIT_CLEAR |->
            fetch_discard == !file_rdata[instr.bit_sel] ##1
            $stable(zero_flag_ff);
    endproperty
    a_skip_clear: assert property (p_skip_clear)
        else $error("Skip if clear decision wrong");

    property p_skip_set;
        @(posedge clk) disable iff (reset)
        accept && instr.op == cbc_pkg::CBC_OP_SKIP_IF_BIT_SET |->
            fetch_discard == file_rdata[instr.bit_sel] ##1
            $stable(zero_flag_ff);
    endproperty
    a_skip_set: assert property (p_skip_set)
        else $error("Skip if set decision wrong");

    property p_skip_len;
        @(posedge clk) disable iff (reset)
        fetch_discard |=> nop_cycle_ff && !instr_ready ##1 instr_ready &&
            pc_ff == $past(pc_ff, 2) + 11'h002;
    endproperty
    a_skip_len: assert property (p_skip_len)
        else $error("Taken skip not two cycles");

    property p_call_push;
        @(posedge clk) disable iff (reset)
        accept && instr.op == cbc_pkg::CBC_OP_COMPUTED_CALL |=>
            stack_ptr_ff == $past(stack_ptr_ff) + 3'h1 &&
            stack_top == $past(pc_ff) + 11'h001;
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("Call return address not pushed");

    property p_call_target;
        @(posedge clk) disable iff (reset)
        accept && instr.op == cbc_pkg::CBC_OP_COMPUTED_CALL |=>
            !instr_ready ##1 instr_ready && $stable(zero_flag_ff) &&
            pc_ff == {$past(call_high_addr_reg[2:0], 2),
                      $past(accumulator_ff, 2)};
    endproperty
    a_call_target: assert property (p_call_target)
        else $error("Call target or length wrong");

    property p_clear_acc;
        @(posedge clk) disable iff (reset)
        accept && instr.op == cbc_pkg::CBC_OP_CLEAR_ACCUMULATOR |=>
            accumulator_ff == 8'h00 && zero_flag_ff && instr_ready;
    endproperty
    a_clear_acc: assert property (p_clear_acc)
        else $error("Clear accumulator wrong");

endmodule : cbc_exec

// *** tb/tb_cpu_bit_logic_call_exec.sv ***
// Self-checking bench for the bit, logic and call executor
`timescale 1ns/100ps

module tb_cpu_bit_logic_call_exec;

    logic                        clk;
    logic                        reset;
    logic                        instr_valid;
    logic                        instr_ready;
    cbc_pkg::cbc_instr_t         instr;
    logic [7:0]                  call_high_addr_reg;
    logic                        acc_load;
    logic [7:0]                  acc_load_data;
    logic [6:0]                  file_raddr;
    logic [7:0]                  file_rdata;
    cbc_pkg::cbc_fwrite_t        file_wr_ff;
    logic                        fetch_discard;
    logic                        nop_cycle_ff;
    logic [7:0]                  accumulator_ff;
    logic                        zero_flag_ff;
    logic [10:0]                 pc_ff;
    logic [2:0]                  stack_ptr_ff;
    logic [10:0]                 stack_top;
    int                          n_errors;
    int                          checks_done;
    logic                        seen_discard;
    logic [10:0]                 exp_pc;

    cbc_exec dut (
        .clk                (clk),
        .reset              (reset),
        .instr_valid        (instr_valid),
        .instr_ready        (instr_ready),
        .instr              (instr),
        .call_high_addr_reg (call_high_addr_reg),
        .acc_load           (acc_load),
        .acc_load_data      (acc_load_data),
        .file_raddr         (file_raddr),
        .file_rdata         (file_rdata),
        .file_wr_ff         (file_wr_ff),
        .fetch_discard      (fetch_discard),
        .nop_cycle_ff       (nop_cycle_ff),
        .accumulator_ff     (accumulator_ff),
        .zero_flag_ff       (zero_flag_ff),
        .pc_ff              (pc_ff),
        .stack_ptr_ff       (stack_ptr_ff),
        .stack_top          (stack_top)
    );

    always #12.5 clk = ~clk;

    //------------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------------
    task automatic check(input string w, input logic [15:0] e,
                         input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", w, e, g);
        end
    endtask : check

    task automatic complete_run();
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1;
        exp_pc = 11'h000;
        check("acc", 16'h0000, accumulator_ff);
        check("zero", 16'h0000, zero_flag_ff);
        check("pc", 16'h0000, pc_ff);
        check("sp", 16'h0000, stack_ptr_ff);
        check("ready", 16'h0001, instr_ready);
        check("we", 16'h0000, file_wr_ff.we);
    endtask : do_reset

    // Waits for idle, presents one instruction, returns after the accept
    task automatic send(input cbc_pkg::cbc_op_t op, input logic [7:0] imm,
                        input logic [6:0] fa, input logic [2:0] sel,
                        input logic [7:0] rd);
        int i;
        for (i = 0; i < 16 && instr_ready !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        if (i == 16)
        begin
            n_errors++;
            complete_run();
        end
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= '{op: op, imm: imm, faddr: fa, bit_sel: sel};
        file_rdata <= rd;
        #1;
        check("raddr", {9'h000, fa}, {9'h000, file_raddr});
        seen_discard = fetch_discard;
        @(posedge clk);
        instr_valid <= 1'b0;
        file_rdata <= ~rd;
        #1;
    endtask : send

    // Accumulator write from outside the block, one cycle
    task automatic load_acc(input logic [7:0] v);
        @(posedge clk);
        acc_load      <= 1'b1;
        acc_load_data <= v;
        @(posedge clk);
        acc_load <= 1'b0;
        #1;
    endtask : load_acc

    //------------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------------
    task automatic t_and();
        load_acc(8'h5A);
        send(cbc_pkg::CBC_OP_AND_IMMEDIATE, 8'hAF, 7'h00, 3'h0, 8'h00);
        exp_pc++;
        check("and acc", 16'h000A, accumulator_ff);
        check("and zero", 16'h0000, zero_flag_ff);
        check("and ready", 16'h0001, instr_ready);
        check("and pc", exp_pc, pc_ff);
        send(cbc_pkg::CBC_OP_NONE, 8'h00, 7'h00, 3'h0, 8'h00);
        exp_pc++;
        check("none acc", 16'h000A, accumulator_ff);
        check("none pc", exp_pc, pc_ff);
        send(cbc_pkg::CBC_OP_AND_IMMEDIATE, 8'h50, 7'h00, 3'h0, 8'h00);
        exp_pc++;
        check("and acc2", 16'h0000, accumulator_ff);
        check("and zero2", 16'h0001, zero_flag_ff);
    endtask : t_and

    task automatic t_clear();
        load_acc(8'h55);
        send(cbc_pkg::CBC_OP_CLEAR_ACCUMULATOR, 8'h55, 7'h00, 3'h0, 8'h00);
        exp_pc++;
        check("clr acc", 16'h0000, accumulator_ff);
        check("clr zero", 16'h0001, zero_flag_ff);
        check("clr ready", 16'h0001, instr_ready);
    endtask : t_clear

    task automatic t_bit_set();
        logic [6:0] fa;
        for (int b = 0; b < 8; b++)
        begin
            fa = b[0] ? 7'h7F : 7'h00;
            send(cbc_pkg::CBC_OP_BIT_SET, 8'h00, fa, b[2:0], 8'h5A);
            exp_pc++;
            check("bs we", 16'h0001, file_wr_ff.we);
            check("bs addr", fa, file_wr_ff.addr);
            check("bs data", 8'h5A | (8'h01 << b), file_wr_ff.data);
            check("bs zero", 16'h0001, zero_flag_ff);
            check("bs ready", 16'h0001, instr_ready);
            check("bs pc", exp_pc, pc_ff);
        end
    endtask : t_bit_set

    task automatic t_skip();
        logic tk;
        for (int k = 0; k < 4; k++)
        begin
            tk = ~k[0];
            send(k < 2 ? cbc_pkg::CBC_OP_SKIP_IF_BIT_CLEAR
                       : cbc_pkg::CBC_OP_SKIP_IF_BIT_SET,
                 8'h00, 7'h33, (k == 0 || k == 3) ? 3'h2 : 3'h3, 8'h5A);
            check("discard", tk, seen_discard);
            check("nop", tk, nop_cycle_ff);
            check("sk ready", !tk, instr_ready);
            check("sk zero", 16'h0001, zero_flag_ff);
            check("sk we", 16'h0000, file_wr_ff.we);
            if (tk)
            begin
                @(posedge clk);
                #1;
                check("nop end", 16'h0000, nop_cycle_ff);
                check("sk ready2", 16'h0001, instr_ready);
            end
            exp_pc = exp_pc + (tk ? 11'h002 : 11'h001);
            check("sk pc", exp_pc, pc_ff);
        end
    endtask : t_skip

    task automatic t_call(input logic [7:0] hi, input logic [7:0] acc,
                          input logic [2:0] sp0);
        load_acc(acc);
        @(posedge clk);
        call_high_addr_reg <= hi;
        send(cbc_pkg::CBC_OP_COMPUTED_CALL, 8'h00, 7'h00, 3'h0, 8'h00);
        check("call sp", sp0 + 3'h1, stack_ptr_ff);
        check("call top", exp_pc + 11'h001, stack_top);
        check("call ready", 16'h0000, instr_ready);
        @(posedge clk);
        #1;
        exp_pc = {hi[2:0], acc};
        check("call pc", exp_pc, pc_ff);
        check("call ready2", 16'h0001, instr_ready);
        check("call zero", 16'h0001, zero_flag_ff);
    endtask : t_call

    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        call_high_addr_reg = 8'h00;
        acc_load = 1'b0;
        acc_load_data = 8'h00;
        file_rdata = 8'h00;
        n_errors = 0;
        checks_done = 0;
        do_reset();
        t_and();
        do_reset();
        t_clear();
        t_bit_set();
        t_skip();
        t_call(8'h02, 8'h34, 3'h0);
        t_call(8'hFD, 8'hC5, 3'h1);
        complete_run();
    end

endmodule : tb_cpu_bit_logic_call_exec
